// ### pmws_consts.svh
// Offsets, field positions, reset values and timing counts of the power-mode sequencer
`ifndef PMWS_CONSTS_SVH
`define PMWS_CONSTS_SVH
// Register byte offsets
`define PMWS_A_CTRL      8'h00
`define PMWS_A_WAKE_EN   8'h04
`define PMWS_A_SLP_PIN   8'h08
`define PMWS_A_RETAIN    8'h0c
`define PMWS_A_STATUS    8'h10
`define PMWS_A_RTC_CMP   8'h14
`define PMWS_A_SENSOR    8'h18
`define PMWS_A_RTC_NOW   8'h1c
// Control register fields
`define PMWS_F_FORCE_LDO 0
`define PMWS_F_LATCH_EN  1
`define PMWS_F_DSR_EN    2
`define PMWS_F_LF_SRC    4
`define PMWS_F_STBY_REQ  8
`define PMWS_F_SLP_REQ   9
`define PMWS_F_OFF_CMD   10
// Sleep-pin register fields
`define PMWS_F_PIN_EN    8
// Sensor register fields
`define PMWS_F_SENS_EN   0
`define PMWS_F_SENS_EDGE 1
// Status register fields
`define PMWS_F_CAUSE     0
`define PMWS_F_STATE     8
`define PMWS_F_BUCK      12
// Reset-cause bit positions
`define PMWS_C_POR       0
`define PMWS_C_HW        1
`define PMWS_C_SW        2
`define PMWS_C_BOR       3
`define PMWS_C_SLEEP     4
// Reset values
`define PMWS_RST_CAUSE   5'h01
`define PMWS_RST_RETAIN  8'hff
`define PMWS_RST_RTC_CMP 32'h0000_8000
// Sizes
`define PMWS_GPIO_N      25
`define PMWS_RAM_SECT    8
// Timing: slow clock rate, RC recalibration period and reboot length
`define PMWS_LF_HZ       32768
`define PMWS_RC_CAL_S    8
`define PMWS_RC_CAL_TICKS (`PMWS_RC_CAL_S * `PMWS_LF_HZ)
`define PMWS_REBOOT_CYC  16
`endif

// ### pmws_pkg.sv
// Types of the power-mode sequencer
package pmws_pkg;
    // Power states, Gray codes along active-standby-sleep-reboot
    typedef enum logic [2:0] {
        ST_ACTIVE  = 3'h0,
        ST_STANDBY = 3'h1,
        ST_SLEEP   = 3'h3,
        ST_REBOOT  = 3'h2,
        ST_SAVE    = 3'h6,
        ST_DOWN    = 3'h7
    } pmws_state_e;

    // Slow clock sources
    typedef enum logic [1:0] {
        LF_XTAL = 2'h0,
        LF_RC   = 2'h1,
        LF_EXT  = 2'h2
    } pmws_lf_e;

    // All state of the sequencer outside the counter module
    typedef struct packed {
        pmws_state_e  st;
        logic [7:0]   cnt;
        logic         force_ldo;
        logic         latch_en;
        logic         dsr_en;
        pmws_lf_e     lf_src;
        logic [24:0]  wake_en;
        logic         pin_en;
        logic [4:0]   pin_idx;
        logic [7:0]   ret_mask;
        logic         sens_en;
        logic         sens_edge;
        logic [31:0]  rtc_cmp;
        logic [4:0]   cause;
        logic [24:0]  gpio_q;
        logic [24:0]  hold;
        logic         sup_q;
        logic         dsr_q;
        logic         sens_q;
        logic         off_to_sleep;
        logic         buck;
        logic [31:0]  prdata;
        logic         pslverr;
    } pmws_regs_s;
endpackage

// ### pmws_rtc.sv
// Slow-clock real-time counter with compare event and RC recalibration timer
`include "pmws_consts.svh"
module pmws_rtc #(
    parameter int unsigned CAL_TICKS = `PMWS_RC_CAL_TICKS
) (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic        lf_clk_in,      // Slow clock level, sampled
    input  wire logic        rc_sel_in,      // RC oscillator selected
    input  wire logic [31:0] cmp_in,         // Compare period in ticks
    output logic [31:0]      now_out,        // Ticks since last match
    output logic             match_out,      // One-cycle event pulse
    output logic             cal_req_out     // One-cycle recalibration pulse
);
    logic        lf_q;                        // Previous slow clock level
    logic [31:0] cal_cnt;                     // Ticks since last calibration
    logic        tick;                        // Slow clock rising edge

    assign tick = lf_clk_in & ~lf_q;

    // Counter keeps running in every power state
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            lf_q        <= 1'b0;
            now_out     <= 32'h0000_0000;
            cal_cnt     <= 32'h0000_0000;
            match_out   <= 1'b0;
            cal_req_out <= 1'b0;
        end else begin
            lf_q        <= lf_clk_in;
            match_out   <= 1'b0;
            cal_req_out <= 1'b0;
            if (tick) begin
                // Periodic compare: restart on match
                if (now_out + 32'h1 >= cmp_in) begin
                    now_out   <= 32'h0000_0000;
                    match_out <= 1'b1;
                end else begin
                    now_out <= now_out + 32'h1;
                end
                // RC drifts, so ask for recalibration each period
                if (rc_sel_in && cal_cnt + 32'h1 >= CAL_TICKS) begin
                    cal_cnt     <= 32'h0000_0000;
                    cal_req_out <= 1'b1;
                end else if (rc_sel_in) begin
                    cal_cnt <= cal_cnt + 32'h1;
                end else begin
                    cal_cnt <= 32'h0000_0000;
                end
            end
        end
    end
endmodule // pmws_rtc

// ### pmws_top.sv
// Power-mode, wake and reset sequencer with APB register slave
// Contract
// - Buck under radio load, linear otherwise
// - Setting forces linear regulator permanently
// - Reboot on supply rise and module reset
// - Enabled pin change wakes from sleep
// - Standby also wakes on counter, sensors
// - Any GPIO may control sleep entry/exit
// - Brown-out shuts down without saving settings
// - Standby keeps RAM and low-power interfaces
// - Standby exits on external/internal/sensor events
// - Three slow sources; RC recalibrated 8 s
// - Sleep stops everything; external wake only
// - Sleep wakes on pin, comparator, field
// - Latch pins in sleep, wake on change
// - Sleep wake reboots, keeps retained RAM
// - Low reset pin reboots without saving
// - Power-off command saves, detaches, resets
// - DSR line switches off with saving
// - Counter events run active and standby
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`include "pmws_consts.svh"
module pmws_top #(
    parameter int unsigned CAL_TICKS  = `PMWS_RC_CAL_TICKS,
    parameter int unsigned REBOOT_CYC = `PMWS_REBOOT_CYC
) (
    input  wire logic         sys_clk_in,
    input  wire logic         reset_in,
    // APB slave
    input  wire logic         psel_in,
    input  wire logic         penable_in,
    input  wire logic         pwrite_in,
    input  wire logic [7:0]   paddr_in,
    input  wire logic [31:0]  pwdata_in,
    output logic [31:0]       prdata_out,
    output logic              pready_out,
    output logic              pslverr_out,
    // Supply and reset pins
    input  wire logic         supply_good_in,  // Supply at valid level
    input  wire logic         brownout_in,     // Supply below minimum
    input  wire logic         hw_reset_n_in,   // Reset pin, pulled high on the pad
    // Wake sources
    input  wire logic [24:0]  gpio_in,
    input  wire logic         lpcomp_in,       // Low-power comparator level
    input  wire logic         sensor_in,       // Programmable sensor level
    input  wire logic         nfc_field_in,    // Field detected
    input  wire logic         radio_wake_in,   // Radio internal event
    input  wire logic         radio_busy_in,   // Radio drawing heavy current
    input  wire logic         dsr_in,          // Host on/off line, high = on
    // Save handshake with firmware
    input  wire logic         nvm_done_in,
    input  wire logic         detach_done_in,
    // Slow clock
    input  wire logic         slow_xtal_in,
    output logic              slow_xtal_out,   // Crystal drive
    // Power controls
    output logic              buck_mode_out,
    output logic              logic_power_en_out,
    output logic              lowpower_if_en_out,
    output logic [7:0]        ram_retain_out,
    output logic [24:0]       gpio_hold_out,
    output logic              gpio_latch_en_out,
    output logic              reboot_out,
    output logic              nvm_save_req_out,
    output logic              detach_req_out,
    output logic              rtc_event_out,
    output logic              rc_cal_req_out,
    output logic [1:0]        lf_src_out
);
    pmws_pkg::pmws_regs_s r_r;    // Registered state
    pmws_pkg::pmws_regs_s r_nxt;  // Next state
    logic [31:0] rtc_now;         // Counter value
    logic        rtc_match;       // Counter event
    logic        acc;             // APB access phase
    logic        wr;              // Write strobe
    logic        sup_rise;        // Supply came good
    logic [24:0] pin_chg;         // Enabled pin changes
    logic        sens_ev;         // Sensor event
    logic        slp_pin_rise;    // Sleep control pin rose

    // Counter and recalibration timer
    pmws_rtc #(.CAL_TICKS(CAL_TICKS)) u_rtc (
        .sys_clk_in  (sys_clk_in),
        .reset_in    (reset_in),
        .lf_clk_in   (slow_xtal_in),
        .rc_sel_in   (r_r.lf_src == pmws_pkg::LF_RC),
        .cmp_in      (r_r.rtc_cmp),
        .now_out     (rtc_now),
        .match_out   (rtc_match),
        .cal_req_out (rc_cal_req_out)
    );

    // Whether an address decodes
    function automatic logic mapped(input logic [7:0] a);
        mapped = a[1:0] == 2'b00 && a <= `PMWS_A_RTC_NOW;
    endfunction

    // Zero wait states; errors flag unmapped addresses
    assign acc         = psel_in & penable_in;
    assign wr          = acc & pwrite_in & mapped(paddr_in);
    assign pready_out  = 1'b1;
    assign prdata_out  = r_r.prdata;
    assign pslverr_out = acc & r_r.pslverr;

    // Event detectors
    assign sup_rise     = supply_good_in & ~r_r.sup_q;
    assign pin_chg      = (gpio_in ^ (r_r.st == pmws_pkg::ST_SLEEP && r_r.latch_en
                          ? r_r.hold : r_r.gpio_q)) & r_r.wake_en;
    assign sens_ev      = r_r.sens_en & (r_r.sens_edge ? sensor_in & ~r_r.sens_q
                                                       : sensor_in);
    assign slp_pin_rise = r_r.pin_en & gpio_in[r_r.pin_idx] & ~r_r.gpio_q[r_r.pin_idx];

    // Next-state logic
    always_comb begin
        r_nxt         = r_r;
        r_nxt.gpio_q  = gpio_in;
        r_nxt.sup_q   = supply_good_in;
        r_nxt.dsr_q   = dsr_in;
        r_nxt.sens_q  = sensor_in;
        // Buck only while active under load and not forced linear
        r_nxt.buck = ~r_r.force_ldo & radio_busy_in & (r_r.st == pmws_pkg::ST_ACTIVE);
        // Read data and error flag captured in the setup cycle; both hold
        // through the access edge so the master never races their update
        if (psel_in && !penable_in) begin
            r_nxt.pslverr = ~mapped(paddr_in);
            unique case (paddr_in)
                `PMWS_A_CTRL: r_nxt.prdata = {26'h0, 2'(r_r.lf_src), 1'b0,
                                              r_r.dsr_en, r_r.latch_en, r_r.force_ldo};
                `PMWS_A_WAKE_EN: r_nxt.prdata = {7'h00, r_r.wake_en};
                `PMWS_A_SLP_PIN: r_nxt.prdata = {23'h0, r_r.pin_en, 3'h0, r_r.pin_idx};
                `PMWS_A_RETAIN:  r_nxt.prdata = {24'h0, r_r.ret_mask};
                `PMWS_A_STATUS:  r_nxt.prdata = {19'h0, r_r.buck, 1'b0, 3'(r_r.st),
                                                 3'h0, r_r.cause};
                `PMWS_A_RTC_CMP: r_nxt.prdata = r_r.rtc_cmp;
                `PMWS_A_SENSOR:  r_nxt.prdata = {30'h0, r_r.sens_edge, r_r.sens_en};
                `PMWS_A_RTC_NOW: r_nxt.prdata = rtc_now;
                default:         r_nxt.prdata = 32'h0000_0000;
            endcase
        end
        // Register writes; command bits act only while active
        if (wr) begin
            unique case (paddr_in)
                `PMWS_A_CTRL: begin
                    r_nxt.force_ldo = pwdata_in[`PMWS_F_FORCE_LDO];
                    r_nxt.latch_en  = pwdata_in[`PMWS_F_LATCH_EN];
                    r_nxt.dsr_en    = pwdata_in[`PMWS_F_DSR_EN];
                    // Unused code keeps the crystal
                    r_nxt.lf_src = pwdata_in[`PMWS_F_LF_SRC+:2] == 2'h3 ? pmws_pkg::LF_XTAL
                                 : pmws_pkg::pmws_lf_e'(pwdata_in[`PMWS_F_LF_SRC+:2]);
                end
                `PMWS_A_WAKE_EN: r_nxt.wake_en = pwdata_in[24:0];
                `PMWS_A_SLP_PIN: begin
                    r_nxt.pin_en  = pwdata_in[`PMWS_F_PIN_EN];
                    r_nxt.pin_idx = pwdata_in[4:0] > 5'd24 ? 5'd24 : pwdata_in[4:0];
                end
                `PMWS_A_RETAIN:  r_nxt.ret_mask = pwdata_in[7:0];
                `PMWS_A_STATUS:  r_nxt.cause = r_r.cause & ~pwdata_in[4:0]; // W1C
                `PMWS_A_RTC_CMP: r_nxt.rtc_cmp = pwdata_in;
                `PMWS_A_SENSOR: begin
                    r_nxt.sens_en   = pwdata_in[`PMWS_F_SENS_EN];
                    r_nxt.sens_edge = pwdata_in[`PMWS_F_SENS_EDGE];
                end
                default: ;
            endcase
        end
        // Power state machine; brown-out outranks the reset pin
        if (brownout_in) begin
            r_nxt.st = pmws_pkg::ST_DOWN; // No save attempted
            r_nxt.cause[`PMWS_C_BOR] = 1'b1;
        end else if (!hw_reset_n_in) begin
            r_nxt.st  = pmws_pkg::ST_REBOOT; // Held while low, no save
            r_nxt.cnt = 8'h00;
            r_nxt.cause[`PMWS_C_HW] = 1'b1;
        end else begin
            unique case (r_r.st)
                pmws_pkg::ST_ACTIVE: begin
                    if (wr && paddr_in == `PMWS_A_CTRL && pwdata_in[`PMWS_F_OFF_CMD]) begin
                        r_nxt.st           = pmws_pkg::ST_SAVE;
                        r_nxt.off_to_sleep = 1'b0;
                    end else if (r_r.dsr_en && r_r.dsr_q && !dsr_in) begin
                        r_nxt.st           = pmws_pkg::ST_SAVE;
                        r_nxt.off_to_sleep = 1'b1;
                    end else if (slp_pin_rise || (wr && paddr_in == `PMWS_A_CTRL &&
                                 pwdata_in[`PMWS_F_SLP_REQ])) begin
                        r_nxt.st   = pmws_pkg::ST_SLEEP;
                        r_nxt.hold = gpio_in; // Snapshot on entry
                    end else if (wr && paddr_in == `PMWS_A_CTRL &&
                                 pwdata_in[`PMWS_F_STBY_REQ]) begin
                        r_nxt.st = pmws_pkg::ST_STANDBY;
                    end
                end
                pmws_pkg::ST_SAVE: begin
                    // Wait for settings stored and network detached
                    if (nvm_done_in && detach_done_in) begin
                        if (r_r.off_to_sleep) begin
                            r_nxt.st   = pmws_pkg::ST_SLEEP;
                            r_nxt.hold = gpio_in;
                        end else begin
                            r_nxt.st  = pmws_pkg::ST_REBOOT;
                            r_nxt.cnt = 8'h00;
                            r_nxt.cause[`PMWS_C_SW] = 1'b1;
                        end
                    end
                end
                pmws_pkg::ST_STANDBY: begin
                    // Pins, counter, radio, field, sensors resume directly
                    if ((|pin_chg) || rtc_match || radio_wake_in || nfc_field_in ||
                        sens_ev) begin
                        r_nxt.st = pmws_pkg::ST_ACTIVE;
                    end
                end
                pmws_pkg::ST_SLEEP: begin
                    // Only pin, comparator, field or on/off line rise wake; then reboot
                    if ((|pin_chg) || lpcomp_in || nfc_field_in ||
                        (r_r.dsr_en && dsr_in && !r_r.dsr_q)) begin
                        r_nxt.st  = pmws_pkg::ST_REBOOT;
                        r_nxt.cnt = 8'h00;
                        r_nxt.cause[`PMWS_C_SLEEP] = 1'b1;
                    end
                end
                pmws_pkg::ST_REBOOT: begin
                    r_nxt.cnt = r_r.cnt + 8'h01;
                    if (r_r.cnt >= 8'(REBOOT_CYC - 1)) begin
                        r_nxt.st = pmws_pkg::ST_ACTIVE;
                    end
                end
                pmws_pkg::ST_DOWN: begin
                    if (sup_rise) begin
                        r_nxt.st  = pmws_pkg::ST_REBOOT;
                        r_nxt.cnt = 8'h00;
                        r_nxt.cause[`PMWS_C_POR] = 1'b1;
                    end
                end
                default: r_nxt.st = pmws_pkg::ST_REBOOT;
            endcase
        end
    end

    // State register; power-on reset records its own cause
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            r_r           <= '0;
            r_r.st        <= pmws_pkg::ST_REBOOT; // Full reboot on power-up
            r_r.cause     <= `PMWS_RST_CAUSE;
            r_r.ret_mask  <= `PMWS_RST_RETAIN;
            r_r.rtc_cmp   <= `PMWS_RST_RTC_CMP;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Outputs by state
    assign buck_mode_out      = r_r.buck;
    assign logic_power_en_out = r_r.st == pmws_pkg::ST_ACTIVE || r_r.st == pmws_pkg::ST_SAVE;
    assign lowpower_if_en_out = r_r.st != pmws_pkg::ST_SLEEP && r_r.st != pmws_pkg::ST_DOWN;
    assign ram_retain_out     = r_r.st == pmws_pkg::ST_SLEEP  ? r_r.ret_mask
                              : r_r.st == pmws_pkg::ST_DOWN   ? 8'h00
                              : 8'hff; // Standby keeps all RAM
    assign gpio_latch_en_out  = r_r.st == pmws_pkg::ST_SLEEP && r_r.latch_en;
    assign gpio_hold_out      = r_r.hold;
    assign reboot_out         = r_r.st == pmws_pkg::ST_REBOOT;
    assign nvm_save_req_out   = r_r.st == pmws_pkg::ST_SAVE;
    assign detach_req_out     = r_r.st == pmws_pkg::ST_SAVE;
    // Counter events reach the CPU side except in sleep
    assign rtc_event_out      = rtc_match && r_r.st != pmws_pkg::ST_SLEEP;
    assign lf_src_out         = 2'(r_r.lf_src);
    assign slow_xtal_out      = r_r.lf_src == pmws_pkg::LF_XTAL & ~slow_xtal_in;

    // Checks
    property p_buck;
        @(posedge sys_clk_in) disable iff (reset_in)
        buck_mode_out |-> $past(radio_busy_in) && !$past(r_r.force_ldo);
    endproperty
    a_buck: assert property (p_buck) else $error("Buck without load or forced");
    property p_ldo;
        @(posedge sys_clk_in) disable iff (reset_in)
        r_r.force_ldo |=> !buck_mode_out;
    endproperty
    a_ldo: assert property (p_ldo) else $error("Buck while forced linear");
    property p_bor;
        @(posedge sys_clk_in) disable iff (reset_in)
        brownout_in |=> r_r.st == pmws_pkg::ST_DOWN && !nvm_save_req_out;
    endproperty
    a_bor: assert property (p_bor) else $error("Brown-out not shut down");
    property p_hw;
        @(posedge sys_clk_in) disable iff (reset_in)
        !hw_reset_n_in && !brownout_in |=> reboot_out && !nvm_save_req_out;
    endproperty
    a_hw: assert property (p_hw) else $error("Reset pin ignored");
    property p_por;
        @(posedge sys_clk_in) disable iff (reset_in)
        r_r.st == pmws_pkg::ST_DOWN && sup_rise && !brownout_in && hw_reset_n_in
        |=> reboot_out && r_r.cause[`PMWS_C_POR];
    endproperty
    a_por: assert property (p_por) else $error("Supply rise without reboot");
    property p_save;
        @(posedge sys_clk_in) disable iff (reset_in)
        nvm_save_req_out |-> detach_req_out && logic_power_en_out && !reboot_out;
    endproperty
    a_save: assert property (p_save) else $error("Save without detach");
    property p_reboot_len;
        @(posedge sys_clk_in) disable iff (reset_in)
        $rose(reboot_out) |-> reboot_out [*4];
    endproperty
    a_reboot_len: assert property (p_reboot_len) else $error("Reboot pulse short");
    property p_slp_wake;
        @(posedge sys_clk_in) disable iff (reset_in)
        r_r.st == pmws_pkg::ST_SLEEP && hw_reset_n_in && !brownout_in &&
        (lpcomp_in || nfc_field_in) |=> reboot_out && r_r.cause[`PMWS_C_SLEEP];
    endproperty
    a_slp_wake: assert property (p_slp_wake) else $error("Sleep wake lost");
    property p_stby;
        @(posedge sys_clk_in) disable iff (reset_in)
        r_r.st == pmws_pkg::ST_STANDBY |-> ram_retain_out == 8'hff &&
            lowpower_if_en_out && !logic_power_en_out;
    endproperty
    a_stby: assert property (p_stby) else $error("Standby power wrong");
    property p_sleep;
        @(posedge sys_clk_in) disable iff (reset_in)
        r_r.st == pmws_pkg::ST_SLEEP |-> ram_retain_out == r_r.ret_mask &&
            !lowpower_if_en_out && !rtc_event_out;
    endproperty
    a_sleep: assert property (p_sleep) else $error("Sleep not stopped");
    c_stby_wake: cover property (@(posedge sys_clk_in) disable iff (reset_in)
        r_r.st == pmws_pkg::ST_STANDBY ##1 r_r.st == pmws_pkg::ST_ACTIVE);
    c_sleep_wake: cover property (@(posedge sys_clk_in) disable iff (reset_in)
        r_r.st == pmws_pkg::ST_SLEEP ##1 reboot_out);
    c_poweroff: cover property (@(posedge sys_clk_in) disable iff (reset_in)
        nvm_save_req_out ##1 reboot_out);
endmodule // pmws_top

// ### pmws_board.sv
// Board-side model: slow clock source and firmware save handshake
module pmws_board (
    input  wire logic       clk_in,
    input  wire logic       save_req_in,
    input  wire logic       detach_req_in,
    input  wire logic [3:0] lag_in,        // Answer delay in cycles
    output logic            slow_clk_out,
    output logic            nvm_done_out,
    output logic            detach_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r;                    // Cycles left before done
    // Free-running 32.768 kHz source, needed in standby
    initial slow_clk_out = 1'b0;
    always #15259 slow_clk_out = ~slow_clk_out;
    // Delay reloads while idle, so slow answers are as real as prompt ones
    always @(posedge clk_in) begin
        if (!save_req_in)
            wait_r <= lag_in;
        else if (wait_r != 4'h0)
            wait_r <= wait_r - 4'h1;
    end
    // Done drops with the request, never left standing
    assign nvm_done_out    = save_req_in && wait_r == 4'h0;
    assign detach_done_out = detach_req_in && wait_r == 4'h0;
endmodule // pmws_board

// ### power_mode_wake_sequencer_tb.sv
// Self-checking bench of the power-mode sequencer
`include "pmws_consts.svh"
module power_mode_wake_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sup = 1, bor = 0, hrn = 1;
    logic        busy = 0, rwk = 0, lp = 0, sens = 0, nfc = 0, dsr = 0, err;
    logic [7:0]  paddr = 8'h00, ret, mask;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [24:0] gpio = 25'h0, hold;
    logic [3:0]  lag = 4'h2;
    logic [4:0]  pin;
    logic        pready, pslverr, xtal, nd, dd, buck, lpen, lpif, rbt, nreq, dreq, lat;
    logic        xo, ev, cal;
    logic [1:0]  lfs;
    int          errors = 0, n_checks = 0, n_ev = 0, n_cal = 0;
    // 200 MHz system clock
    always #2.5 clk = ~clk;
    pmws_top #(.CAL_TICKS(4)) dut (.sys_clk_in(clk), .reset_in(rst), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .supply_good_in(sup), .brownout_in(bor), .hw_reset_n_in(hrn), .gpio_in(gpio),
        .lpcomp_in(lp), .sensor_in(sens), .nfc_field_in(nfc), .radio_wake_in(rwk),
        .radio_busy_in(busy), .dsr_in(dsr), .nvm_done_in(nd), .detach_done_in(dd),
        .slow_xtal_in(xtal), .slow_xtal_out(xo), .buck_mode_out(buck),
        .logic_power_en_out(lpen), .lowpower_if_en_out(lpif), .ram_retain_out(ret),
        .gpio_hold_out(hold), .gpio_latch_en_out(lat), .reboot_out(rbt),
        .nvm_save_req_out(nreq), .detach_req_out(dreq), .rtc_event_out(ev),
        .rc_cal_req_out(cal), .lf_src_out(lfs));
    // Count counter and recalibration pulses at the falling edge, where they are settled
    always @(negedge clk) begin
        n_ev  <= n_ev + int'(ev);
        n_cal <= n_cal + int'(cal);
    end
    pmws_board board (.clk_in(clk), .save_req_in(nreq), .detach_req_in(dreq), .lag_in(lag),
        .slow_clk_out(xtal), .nvm_done_out(nd), .detach_done_out(dd));
    // Single comparison point
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Verdict and end of run
    task results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One APB transfer; outputs read at the edge where pready is sampled
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, pen} <= 2'b00;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Let the reboot finish, read the cause field, then clear it
    task cause(input logic [4:0] e);
        cyc(24);
        apb(0, `PMWS_A_STATUS, 0);
        chk(rd[4:0], e, "cause");
        apb(1, `PMWS_A_STATUS, 32'h1f);
    endtask
    // Watchdog, well beyond the thirty-two thousand cycles the run needs at most
    initial begin
        #300us;
        errors++;
        results;
    end
    // Main sequence
    initial begin
        void'($urandom(3998));
        cyc(8);
        rst <= 1'b0;
        cyc(1);
        chk(rbt, 1, "reboot");
        chk(xo, !xtal, "crystal drive");
        cause(5'h01);
        apb(0, 8'h22, 0);
        chk(err, 1, "unmapped");
        busy <= 1'b1;
        cyc(3);
        chk(buck, 1, "buck");
        apb(1, `PMWS_A_CTRL, 32'h1);
        cyc(3);
        chk(buck, 0, "forced linear");
        busy <= 1'b0;
        apb(1, `PMWS_A_SENSOR, 32'h1);
        // Standby on the RC source; wake by sensor, radio, then counter alone
        for (int j = 0; j < 3; j++) begin
            if (j == 2)
                apb(1, `PMWS_A_RTC_CMP, 32'h1);
            apb(1, `PMWS_A_CTRL, 32'h110);
            cyc(3);
            chk({lpen, lpif, lfs, xo}, 5'h0a, "standby power");
            {rwk, sens} <= 2'((j + 1) % 3);
            for (int k = 0; k < 7000 && lpen !== 1'b1; k++) @(posedge clk);
            {rwk, sens} <= 2'b00;
            chk({lpen, rbt}, 2'b10, "standby exit");
        end
        // Four slow ticks on RC ask for one recalibration
        cyc(25000);
        chk(n_cal != 0, 1, "rc recalibration");
        chk(n_ev != 0, 1, "counter event");
        // Random pin, mask and pin levels for each sleep round
        for (int i = 0; i < 4; i++) begin
            pin = 5'($urandom % 25);
            mask = 8'($urandom);
            gpio <= 25'($urandom);
            apb(1, `PMWS_A_WAKE_EN, 32'h1 << pin);
            apb(1, `PMWS_A_RETAIN, {24'h0, mask});
            apb(1, `PMWS_A_CTRL, 32'h202);
            cyc(3);
            chk(ret, mask, "retention");
            chk({lat, hold}, {1'b1, gpio}, "latched pins");
            gpio[(pin + 1) % 25] <= ~gpio[(pin + 1) % 25];
            cyc(3);
            chk(rbt, 0, "disabled pin");
            gpio[pin] <= ~gpio[pin];
            cyc(3);
            chk(rbt, 1, "pin wake");
            cause(5'h10);
        end
        // Field, then comparator, each wakes sleep into a reboot
        for (int j = 0; j < 2; j++) begin
            apb(1, `PMWS_A_CTRL, 32'h200);
            cyc(3);
            {lp, nfc} <= 2'(j + 1);
            cyc(3);
            {lp, nfc} <= 2'b00;
            chk(rbt, 1, "sleep wake");
            cause(5'h10);
        end
        // The configured pin rising enters sleep, falling wakes it
        gpio[pin] <= 1'b0;
        apb(1, `PMWS_A_SLP_PIN, 32'h100 | pin);
        gpio[pin] <= 1'b1;
        cyc(3);
        chk(lpif, 0, "pin sleep");
        gpio[pin] <= 1'b0;
        cyc(3);
        chk(rbt, 1, "pin exit");
        cause(5'h10);
        lag <= 4'(2 + $urandom % 14);
        // Host drops the on/off line: save, then sleep; raising it wakes
        dsr <= 1'b1;
        apb(1, `PMWS_A_CTRL, 32'h4);
        dsr <= 1'b0;
        cyc(2);
        chk({nreq, dreq}, 2'b11, "dsr save");
        cyc(20);
        chk({lpif, rbt}, 2'b00, "dsr sleep");
        dsr <= 1'b1;
        cyc(3);
        chk(rbt, 1, "dsr wake");
        cause(5'h10);
        apb(1, `PMWS_A_CTRL, 32'h400);
        cyc(2);
        chk({nreq, dreq}, 2'b11, "save and detach");
        cause(5'h04);
        hrn <= 1'b0;
        cyc(3);
        chk({rbt, nreq}, 2'b10, "pin reset");
        hrn <= 1'b1;
        cause(5'h02);
        {bor, sup} <= 2'b10;
        cyc(3);
        chk({ret, nreq}, 9'h0, "brown-out");
        bor <= 1'b0;
        cyc(2);
        sup <= 1'b1;
        cyc(3);
        chk(rbt, 1, "supply rise");
        cause(5'h09);
        results;
    end
endmodule // power_mode_wake_sequencer_tb
